// [logic/sdg_pkg.sv]
// package: register map, field layout and timing constants of the stall gate
`default_nettype none
package sdg_pkg;
  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int LOAD_W = 10; // load result, unsigned
  localparam int OFFS_W = 7; // threshold offset, signed -64..+63
  localparam int GATE_W = 20; // velocity gates and step period
  localparam int WIDE_W = 12; // signed headroom for offset arithmetic
  localparam int ACC_W = 12; // sum of four load samples
  localparam int CNT_W = 2; // sample counter of the filter
  localparam int DIV_W = 4; // step period prescaler
  localparam int OFFS_SHIFT = 4; // one offset unit moves the reading by 16
  localparam int AVG_SHIFT = 2; // divide by four
  // ------------------------------------------------------------
  // constants of the logic
  // ------------------------------------------------------------
  localparam logic [CNT_W-1:0] FILT_LAST = 2'h3; // fourth sample of a period
  localparam logic [DIV_W-1:0] DIV_LAST = 4'hF; // tick every 16 clocks
  localparam logic [GATE_W-1:0] PERIOD_MAX = 20'hFFFFF; // saturation value
  localparam logic [LOAD_W-1:0] LOAD_MAX = 10'h3FF;
  localparam logic [GATE_W-1:0] GATE_RST = 20'h00000; // gates closed after reset
  localparam logic [OFFS_W-1:0] OFFS_RST = 7'h00; // starting offset is zero
  localparam logic signed [OFFS_W-1:0] OFFS_TOP = 7'sd63;
  // ------------------------------------------------------------
  // apb register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_OFFS = 8'h04;
  localparam logic [7:0] REG_LOWG = 8'h08;
  localparam logic [7:0] REG_HIGHG = 8'h0C;
  localparam logic [7:0] REG_RESULT = 8'h10;
  localparam logic [7:0] REG_PERIOD = 8'h14;
  localparam logic [7:0] REG_IRQ_STAT = 8'h18;
  localparam logic [7:0] REG_IRQ_MASK = 8'h1C;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTRL_FILT_BIT = 0; // load filter enable
  localparam int CTRL_DSEL_BIT = 1; // 0: diag zero, 1: diag one
  localparam int RES_STALL_BIT = 16; // last result was a stall
  localparam int IRQ_STALL_BIT = 0;
  localparam int IRQ_UPD_BIT = 1;
  localparam int IRQ_W = 2;
  localparam logic [31:0] RD_ZERO = 32'h00000000;
endpackage : sdg_pkg
`default_nettype wire

// [logic/sdg_filt_if.sv]
// interface: samples into and results out of the load filter
`default_nettype none
interface sdg_filt_if;
  import sdg_pkg::*;
  logic sample_valid; // one cycle per full step
  logic [LOAD_W-1:0] sample; // offset-corrected reading
  logic filt_en; // average over four samples
  logic result_valid; // one cycle per new result
  logic [LOAD_W-1:0] result; // filtered or single reading
  modport ctrl (output sample_valid, output sample, output filt_en,
                input result_valid, input result);
  modport filt (input sample_valid, input sample, input filt_en,
                output result_valid, output result);
endinterface : sdg_filt_if
`default_nettype wire

// [logic/sdg_load_filter.sv]
// load filter: passes single readings or averages four of them
`default_nettype none
module sdg_load_filter
  import sdg_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  sdg_filt_if.filt fi
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [CNT_W-1:0] cnt, next_cnt; // samples taken this period
  logic [ACC_W-1:0] acc, next_acc; // running sum
  logic valid, next_valid;
  logic [LOAD_W-1:0] res, next_res;
  logic [ACC_W-1:0] sum; // sum including current sample

  assign sum = acc + {{(ACC_W-LOAD_W){1'b0}}, fi.sample};
  assign fi.result_valid = valid;
  assign fi.result = res;

  // next state: one result per sample, or one per four
  always_comb begin
    next_cnt = cnt;
    next_acc = acc;
    next_valid = 1'b0;
    next_res = res;
    if (fi.sample_valid) begin
      if (!fi.filt_en) begin
        // unfiltered: every full step gives a result
        next_valid = 1'b1;
        next_res = fi.sample;
        next_cnt = '0;
        next_acc = '0;
      end else if (cnt == FILT_LAST) begin
        // fourth step closes one electrical period
        next_valid = 1'b1;
        next_res = LOAD_W'(sum >> AVG_SHIFT);
        next_cnt = '0;
        next_acc = '0;
      end else begin
        // collect, no result yet
        next_acc = sum;
        next_cnt = cnt + 2'h1;
      end
    end
  end

  // registers only
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cnt <= '0;
      acc <= '0;
      valid <= 1'b0;
      res <= '0;
    end else begin
      cnt <= next_cnt;
      acc <= next_acc;
      valid <= next_valid;
      res <= next_res;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_filt_four_steps: assert property (
    (fi.sample_valid && fi.filt_en && cnt == FILT_LAST) |=> valid)
    else $error("filtered result missing after fourth sample");
  a_filt_no_early: assert property (
    (fi.sample_valid && fi.filt_en && cnt != FILT_LAST) |=> !valid)
    else $error("filtered result before fourth sample");
  a_filt_average: assert property (
    (fi.sample_valid && fi.filt_en && cnt == FILT_LAST) |=>
      res == LOAD_W'($past(sum) >> AVG_SHIFT))
    else $error("filtered result is not the mean of four");
endmodule : sdg_load_filter
`default_nettype wire

// [logic/sdg_stall_gate.sv]
// top: load result, velocity gating, stall pulse and apb registers
`default_nettype none
module sdg_stall_gate
  import sdg_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic full_step_in, // one-cycle pulse per full step
  input wire logic [LOAD_W-1:0] raw_load_in, // back-emf reading, valid with step
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic diag_output_zero_out,
  output logic diag_output_one_out,
  output logic irq_out
);
  // ------------------------------------------------------------
  // configuration and status state
  // ------------------------------------------------------------
  logic filt_en, next_filt_en; // averaging over four steps
  logic diag_sel, next_diag_sel; // which diag pin carries the pulse
  logic [OFFS_W-1:0] stall_threshold_offset, next_offs; // signed
  logic [GATE_W-1:0] low_velocity_gate, next_lowg; // longest period allowed
  logic [GATE_W-1:0] high_velocity_gate, next_highg; // shortest period, 0 = none
  logic [LOAD_W-1:0] load_measure_result, next_result;
  logic stall_flag, next_stall_flag; // last result was a stall
  logic stall_pulse, next_stall_pulse; // one cycle per stall
  logic [IRQ_W-1:0] irq_stat, next_irq_stat; // sticky events
  logic [IRQ_W-1:0] irq_mask, next_irq_mask;
  logic [31:0] rd_data, next_rd_data; // read data, captured at setup
  logic diag0, next_diag0;
  logic diag_output_one, next_diag_output_one;
  // step period measurement
  logic [DIV_W-1:0] div_cnt, next_div_cnt; // prescaler
  logic [GATE_W-1:0] period_cnt, next_period_cnt; // ticks since last step
  logic [GATE_W-1:0] step_period_measure, next_period;
  // decoded
  logic gate_open; // velocity inside the window
  logic wr_acc; // write access phase
  logic rd_setup; // read setup phase
  logic addr_ok; // address is mapped
  logic result_update; // one cycle per new result
  logic [IRQ_W-1:0] irq_set; // events this cycle
  logic signed [WIDE_W-1:0] corrected; // reading after offset
  logic [LOAD_W-1:0] adjusted; // clamped into result range

  sdg_filt_if fi ();

  // ------------------------------------------------------------
  // offset correction of each raw reading
  // ------------------------------------------------------------
  // saturating step of a period counter
  function automatic logic [GATE_W-1:0] sat_inc(input logic [GATE_W-1:0] v);
    sat_inc = (v == PERIOD_MAX) ? v : v + 20'h00001;
  endfunction : sat_inc

  // positive offset raises the reading, so a zero needs more load
  always_comb begin
    corrected = $signed({2'b00, raw_load_in})
      + ($signed({{(WIDE_W-OFFS_W){stall_threshold_offset[OFFS_W-1]}},
                 stall_threshold_offset}) <<< OFFS_SHIFT);
    if (corrected < 0) begin
      adjusted = '0; // clamp: heavy load or large offset
    end else if (corrected > $signed({2'b00, LOAD_MAX})) begin
      adjusted = LOAD_MAX;
    end else begin
      adjusted = corrected[LOAD_W-1:0];
    end
  end

  assign fi.sample_valid = full_step_in;
  assign fi.sample = adjusted;
  assign fi.filt_en = filt_en;

  sdg_load_filter u_filt (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .fi(fi)
  );

  // ------------------------------------------------------------
  // velocity window
  // ------------------------------------------------------------
  // longer period means slower motor; high gate of zero disables upper limit
  assign gate_open = (step_period_measure <= low_velocity_gate)
    && (step_period_measure >= high_velocity_gate);

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign addr_ok = (paddr == REG_CTRL) || (paddr == REG_OFFS) || (paddr == REG_LOWG)
    || (paddr == REG_HIGHG) || (paddr == REG_RESULT) || (paddr == REG_PERIOD)
    || (paddr == REG_IRQ_STAT) || (paddr == REG_IRQ_MASK);
  assign pready = 1'b1; // zero wait states
  assign pslverr = psel && penable && !addr_ok; // unmapped address
  assign prdata = rd_data;
  assign result_update = fi.result_valid;
  assign irq_set[IRQ_STALL_BIT] = next_stall_pulse;
  assign irq_set[IRQ_UPD_BIT] = result_update;
  assign diag_output_zero_out = diag0;
  assign diag_output_one_out = diag_output_one;
  assign irq_out = |(irq_stat & irq_mask);

  // ------------------------------------------------------------
  // next values
  // ------------------------------------------------------------
  always_comb begin
    next_filt_en = filt_en;
    next_diag_sel = diag_sel;
    next_offs = stall_threshold_offset;
    next_lowg = low_velocity_gate;
    next_highg = high_velocity_gate;
    next_irq_mask = irq_mask;
    next_rd_data = rd_data;
    next_result = load_measure_result;
    next_stall_flag = stall_flag;
    next_stall_pulse = 1'b0;
    // register writes take effect in the access phase
    if (wr_acc) begin
      unique case (paddr)
        REG_CTRL: begin
          next_filt_en = pwdata[CTRL_FILT_BIT];
          next_diag_sel = pwdata[CTRL_DSEL_BIT];
        end
        REG_OFFS: begin
          next_offs = pwdata[OFFS_W-1:0];
        end
        REG_LOWG: next_lowg = pwdata[GATE_W-1:0];
        REG_HIGHG: next_highg = pwdata[GATE_W-1:0];
        REG_IRQ_MASK: next_irq_mask = pwdata[IRQ_W-1:0];
        default: ; // read-only, status or unmapped
      endcase
    end
    // set wins over the write-one clear
    next_irq_stat = irq_stat;
    if (wr_acc && paddr == REG_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~pwdata[IRQ_W-1:0];
    end
    next_irq_stat = next_irq_stat | irq_set;
    // read data captured in setup so it comes from a flop
    if (rd_setup) begin
      unique case (paddr)
        REG_CTRL: next_rd_data = RD_ZERO | (32'(filt_en) << CTRL_FILT_BIT)
          | (32'(diag_sel) << CTRL_DSEL_BIT);
        REG_OFFS: next_rd_data = {{(32-OFFS_W){stall_threshold_offset[OFFS_W-1]}},
          stall_threshold_offset};
        REG_LOWG: next_rd_data = 32'(low_velocity_gate);
        REG_HIGHG: next_rd_data = 32'(high_velocity_gate);
        REG_RESULT: next_rd_data = 32'(load_measure_result)
          | (32'(stall_flag) << RES_STALL_BIT);
        REG_PERIOD: next_rd_data = 32'(step_period_measure);
        REG_IRQ_STAT: next_rd_data = 32'(irq_stat);
        REG_IRQ_MASK: next_rd_data = 32'(irq_mask);
        default: next_rd_data = RD_ZERO;
      endcase
    end
    // result refresh, only when the filter hands one over
    if (result_update) begin
      if (gate_open && fi.result == '0) begin
        next_result = '0;
        next_stall_flag = 1'b1;
        next_stall_pulse = 1'b1;
      end else begin
        next_result = fi.result;
        next_stall_flag = 1'b0;
      end
    end
    // one pulse per stall; the controller needs no second one
    // diag pulse trails the stall pulse by one cycle, after the result is visible
    next_diag0 = stall_pulse && !diag_sel;
    next_diag_output_one = stall_pulse && diag_sel;
    // step period in ticks of sixteen clocks
    next_div_cnt = div_cnt + 4'h1;
    next_period_cnt = period_cnt;
    next_period = step_period_measure;
    if (full_step_in) begin
      next_period = period_cnt;
      next_period_cnt = '0;
      next_div_cnt = '0;
    end else if (div_cnt == DIV_LAST) begin
      next_period_cnt = sat_inc(period_cnt); // saturates: standstill reads max
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      filt_en <= 1'b0;
      diag_sel <= 1'b0;
      stall_threshold_offset <= OFFS_RST;
      low_velocity_gate <= GATE_RST;
      high_velocity_gate <= GATE_RST;
      irq_mask <= '0;
      irq_stat <= '0;
      rd_data <= RD_ZERO;
      load_measure_result <= '0;
      stall_flag <= 1'b0;
      stall_pulse <= 1'b0;
      diag0 <= 1'b0;
      diag_output_one <= 1'b0;
      div_cnt <= '0;
      period_cnt <= PERIOD_MAX; // counts as standstill until first step
      step_period_measure <= PERIOD_MAX;
    end else begin
      filt_en <= next_filt_en;
      diag_sel <= next_diag_sel;
      stall_threshold_offset <= next_offs;
      low_velocity_gate <= next_lowg;
      high_velocity_gate <= next_highg;
      irq_mask <= next_irq_mask;
      irq_stat <= next_irq_stat;
      rd_data <= next_rd_data;
      load_measure_result <= next_result;
      stall_flag <= next_stall_flag;
      stall_pulse <= next_stall_pulse;
      diag0 <= next_diag0;
      diag_output_one <= next_diag_output_one;
      div_cnt <= next_div_cnt;
      period_cnt <= next_period_cnt;
      step_period_measure <= next_period;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_unfilt_step_result: assert property (
    (full_step_in && !filt_en && !wr_acc) |=> result_update
      ##1 (load_measure_result == $past(fi.result) || stall_flag))
    else $error("no result two cycles after an unfiltered step");
  a_result_needs_step: assert property (
    $changed(load_measure_result) |-> $past(result_update))
    else $error("result changed without a new measurement");
  a_stall_in_window: assert property (
    stall_pulse |-> $past(gate_open))
    else $error("stall reported outside velocity window");
  a_stall_zero_result: assert property (
    stall_pulse |-> load_measure_result == '0 && stall_flag)
    else $error("stall without zero result");
  a_diag_route: assert property (
    stall_pulse |=> (diag_output_zero_out == !$past(diag_sel))
      && (diag_output_one_out == $past(diag_sel)))
    else $error("stall pulse on wrong diag output");
  a_offset_zero_pass: assert property (
    stall_threshold_offset == OFFS_RST |-> adjusted == raw_load_in)
    else $error("zero offset altered the reading");
  a_offset_top_keep: assert property (
    (wr_acc && paddr == REG_OFFS && $signed(pwdata[OFFS_W-1:0]) == OFFS_TOP)
      |=> $signed(stall_threshold_offset) == OFFS_TOP)
    else $error("offset of plus sixty-three not accepted");
  a_low_gate_cmp: assert property (
    (step_period_measure > low_velocity_gate) |-> !gate_open)
    else $error("lower gate open although step period too long");
  a_irq_set_sticky: assert property (
    ($past(irq_set) != '0) |-> ((irq_stat & $past(irq_set)) == $past(irq_set)))
    else $error("interrupt event lost in status");

  c_stall_diag0: cover property (stall_pulse ##1 diag_output_zero_out);
  c_stall_diag_output_one: cover property (stall_pulse ##1 diag_output_one_out);
  c_filtered_result: cover property (filt_en && result_update);
  c_gated_zero: cover property (result_update && fi.result == '0 && !gate_open);
endmodule : sdg_stall_gate
`default_nettype wire

// [sim/sdg_ctrl_model.sv]
// partner model: motion controller that issues full steps and halts on a stall pulse
`default_nettype none
module sdg_ctrl_model (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic start_in, // begin a move
  input wire logic [7:0] n_steps_in, // steps in the move
  input wire logic [7:0] gap_in, // cycles between steps, at least one
  input wire logic diag_sel_in, // which diag line is wired to us
  input wire logic diag_zero_in,
  input wire logic diag_one_in,
  output logic full_step_out,
  output logic [7:0] steps_done_out,
  output logic busy_out,
  output logic stopped_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] timer; // cycles left to the next step
  logic pulse_seen; // watched diag line is high
  assign pulse_seen = diag_sel_in ? diag_one_in : diag_zero_in;
  // ------------------------------------------------------------
  // step sequencer
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      full_step_out <= 1'b0;
      steps_done_out <= 8'h00;
      busy_out <= 1'b0;
      stopped_out <= 1'b0;
      timer <= 8'h00;
    end else begin
      full_step_out <= 1'b0; // steps are single-cycle pulses
      if (start_in) begin
        busy_out <= 1'b1;
        steps_done_out <= 8'h00;
        stopped_out <= 1'b0;
        timer <= gap_in;
      end else if (busy_out && pulse_seen) begin
        busy_out <= 1'b0; // one pulse is enough, no waiting for more
        stopped_out <= 1'b1;
      end else if (busy_out && timer == 8'h00) begin
        if (steps_done_out == n_steps_in) begin
          busy_out <= 1'b0; // move done, last step had a full gap to answer
        end else begin
          full_step_out <= 1'b1;
          steps_done_out <= steps_done_out + 8'h01;
          timer <= gap_in;
        end
      end else if (busy_out) begin
        timer <= timer - 8'h01;
      end
    end
  end
endmodule : sdg_ctrl_model
`default_nettype wire

// [sim/sdg_stall_gate_tb.sv]
// testbench: stall gate driven over apb and by the controller model
`default_nettype none
module sdg_stall_gate_tb
  import sdg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic diag0;
  logic diag_output_one;
  logic irq;
  logic full_step;
  logic [LOAD_W-1:0] raw_load; // reading follows the step count
  logic [LOAD_W-1:0] load_base = 10'h000;
  logic [LOAD_W-1:0] load_inc = 10'h000;
  logic start = 1'b0;
  logic [7:0] n_steps = 8'h00;
  logic [7:0] gap = 8'h40;
  logic diag_sel = 1'b0;
  logic [7:0] steps_done;
  logic busy;
  logic stopped;
  int d0_cnt; // high cycles seen on each diag line since reset
  int d1_cnt;
  int mismatches = 0;
  int num_checks = 0;
  assign raw_load = load_base + load_inc * {2'h0, steps_done};
  always #4 ref_clk_in = ~ref_clk_in;
  // pulse counters, cleared by every reset
  always @(posedge ref_clk_in) begin
    d0_cnt <= sys_rst_in ? 0 : d0_cnt + int'(diag0);
    d1_cnt <= sys_rst_in ? 0 : d1_cnt + int'(diag_output_one);
  end
  sdg_stall_gate i_sdg_stall_gate (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .full_step_in(full_step), .raw_load_in(raw_load), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .diag_output_zero_out(diag0), .diag_output_one_out(diag_output_one),
    .irq_out(irq));
  sdg_ctrl_model i_sdg_ctrl_model (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .start_in(start), .n_steps_in(n_steps), .gap_in(gap), .diag_sel_in(diag_sel),
    .diag_zero_in(diag0), .diag_one_in(diag_output_one), .full_step_out(full_step),
    .steps_done_out(steps_done), .busy_out(busy), .stopped_out(stopped));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic conclude();
    if (mismatches == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask : chk
  task automatic do_reset();
    @(posedge ref_clk_in);
    sys_rst_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
  endtask : do_reset
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk("apb pready timeout", 32'h1, 32'h0);
      conclude();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(a, 1'b1, d, q, e);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
    logic [31:0] q;
    logic e;
    apb(a, 1'b0, 32'h0, q, e);
    chk(name, exp, q);
  endtask : rd_chk
  // start a move and wait, bounded, until the controller is idle again
  task automatic run_steps(input logic [7:0] n, input logic [7:0] g);
    int k;
    k = 0;
    n_steps <= n;
    gap <= g;
    start <= 1'b1;
    @(posedge ref_clk_in);
    start <= 1'b0;
    do begin
      @(posedge ref_clk_in);
      k++;
    end while (busy !== 1'b0 && k < 4000);
    if (k >= 4000) begin
      chk("move timeout", 32'h1, 32'h0);
      conclude();
    end
    @(negedge ref_clk_in);
  endtask : run_steps
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset_values();
    logic [31:0] q;
    logic e;
    do_reset();
    rd_chk(REG_OFFS, 32'h0, "offset start");
    rd_chk(REG_PERIOD, 32'h000FFFFF, "period start");
    wr(REG_RESULT, 32'hFFFFFFFF);
    rd_chk(REG_RESULT, 32'h0, "result read only");
    apb(8'h20, 1'b0, 32'h0, q, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("irq idle", 32'h0, {31'h0, irq});
  endtask : t_reset_values
  task automatic t_single_steps();
    do_reset();
    load_base <= 10'h0C8;
    load_inc <= 10'h010;
    run_steps(8'h03, 8'h40);
    rd_chk(REG_RESULT, 32'h000000F8, "single result");
    rd_chk(REG_IRQ_STAT, 32'h2, "update flag");
    wr(REG_IRQ_STAT, 32'h2);
    repeat (100) @(posedge ref_clk_in);
    rd_chk(REG_IRQ_STAT, 32'h0, "no update without step");
  endtask : t_single_steps
  task automatic t_filtered();
    do_reset();
    wr(REG_CTRL, 32'h1);
    load_base <= 10'h0C8;
    load_inc <= 10'h010;
    run_steps(8'h03, 8'h40);
    rd_chk(REG_IRQ_STAT, 32'h0, "no update in three steps");
    load_base <= 10'h0F8;
    run_steps(8'h01, 8'h40);
    rd_chk(REG_RESULT, 32'h000000F0, "four step average");
    rd_chk(REG_IRQ_STAT, 32'h2, "update on fourth step");
  endtask : t_filtered
  // raising the offset raises the reading; result clamps to ten bits
  task automatic t_offsets();
    logic [6:0] offs [4] = '{7'h3F, 7'h7E, 7'h7F, 7'h01};
    logic [9:0] raw [4] = '{10'h000, 10'h064, 10'h000, 10'h3FC};
    logic [9:0] res [4] = '{10'h3F0, 10'h044, 10'h000, 10'h3FF};
    do_reset();
    load_inc <= 10'h000;
    for (int i = 0; i < 4; i++) begin
      wr(REG_OFFS, {25'h0, offs[i]});
      rd_chk(REG_OFFS, {{25{offs[i][6]}}, offs[i]}, "offset readback");
      load_base <= raw[i];
      run_steps(8'h01, 8'h40);
      rd_chk(REG_RESULT, {22'h0, res[i]}, "offset result");
    end
  endtask : t_offsets
  task automatic t_stall_route();
    for (int s = 0; s < 2; s++) begin
      do_reset();
      diag_sel <= s[0];
      load_base <= 10'h000;
      load_inc <= 10'h000;
      wr(REG_CTRL, {30'h0, s[0], 1'b0});
      wr(REG_LOWG, 32'h64);
      run_steps(8'h08, 8'h40);
      chk("stopped", 32'h1, {31'h0, stopped});
      chk("stop early", 32'h1, {31'h0, steps_done inside {8'h02, 8'h03}});
      chk("diag zero pulse", 32'(s == 0), 32'(d0_cnt));
      chk("diag one pulse", 32'(s == 1), 32'(d1_cnt));
      rd_chk(REG_RESULT, 32'h00010000, "stall result");
      rd_chk(REG_IRQ_STAT, 32'h3, "stall status");
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(REG_IRQ_MASK, 32'h1);
      @(negedge ref_clk_in);
      chk("irq raised", 32'h1, {31'h0, irq});
      wr(REG_IRQ_STAT, 32'h1);
      @(negedge ref_clk_in);
      chk("irq cleared", 32'h0, {31'h0, irq});
    end
  endtask : t_stall_route
  // step period is 4 ticks: above, below and inside the window
  task automatic t_gate_window();
    logic [31:0] lows [3] = '{32'h1, 32'h64, 32'h64};
    logic [31:0] highs [3] = '{32'h0, 32'h32, 32'h2};
    logic stall [3] = '{1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 3; i++) begin
      do_reset();
      diag_sel <= 1'b0;
      load_base <= 10'h000;
      wr(REG_LOWG, lows[i]);
      wr(REG_HIGHG, highs[i]);
      run_steps(8'h06, 8'h40);
      chk("gate pulses", {31'h0, stall[i]}, 32'(d0_cnt));
      rd_chk(REG_RESULT, {15'h0, stall[i], 16'h0}, "gate result");
    end
  endtask : t_gate_window
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    do_reset();
    t_reset_values();
    t_single_steps();
    t_filtered();
    t_offsets();
    t_stall_route();
    t_gate_window();
    conclude();
  end
endmodule : sdg_stall_gate_tb
`default_nettype wire
